// ### pkg/tms_pkg.sv
/*
  Shared constants and carrier types of the temperature monitor sequencer.
  Assumes a 100 MHz system clock and an ADC front end delivering 11-bit results.
*/
package tms_pkg;

	// -------------------------------------------------------------
	// Clock and timing
	// -------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int TIMEOUT_MIN_US = 25000;
	localparam int TIMEOUT_MAX_US = 45000;
	// The least time rounds up; at whole microseconds it is exact.
	localparam int TIMEOUT_CYCLES = TIMEOUT_MIN_US * CLK_MHZ;
	localparam int TIMEOUT_W = 22;

	// -------------------------------------------------------------
	// Channels and sequence
	// -------------------------------------------------------------
	localparam int CHAN_W = 3;
	localparam logic [2:0] CH_LOCAL = 3'h0;
	localparam logic [2:0] CH_1 = 3'h1;
	localparam logic [2:0] CH_2 = 3'h2;
	localparam logic [2:0] CH_3 = 3'h3;
	localparam logic [2:0] CH_4 = 3'h4;
	localparam logic [2:0] SEQ_LAST_DEF = 3'h4;
	localparam logic [2:0] SEQ_LAST_FAST = 3'h7;
	localparam logic [2:0] SEQ_FIRST = 3'h0;

	// -------------------------------------------------------------
	// Data widths and reset values
	// -------------------------------------------------------------
	localparam int WIDE_W = 11;
	localparam int NARROW_W = 8;
	localparam int EXT_BITS = 3;
	localparam logic [10:0] TEMP_WIDE_RST = 11'h000;
	localparam logic [7:0] TEMP_NARROW_RST = 8'h00;

	typedef struct packed {
		logic [10:0] ch1;
		logic [7:0] ch2;
		logic [7:0] ch3;
		logic [7:0] local_ch;
		logic [7:0] ch4;
	} tms_temps_t;

	typedef struct packed {
		logic [7:0] alert_ch1;
		logic [7:0] alert_ch2;
		logic [7:0] alert_ch3;
		logic [7:0] alert_local;
		logic [7:0] alert_ch4;
		logic [7:0] thermal_shutdown_n_ch1;
		logic [7:0] thermal_shutdown_n_ch4;
	} tms_limits_t;

	typedef struct packed {
		logic ok;
		logic [10:0] data;
	} tms_conv_t;

endpackage

// ### core/tms_sequencer.sv
/*
  Conversion sequencer, standby control, alarm outputs and bus timeout monitor.
  Assumes the register map supplies configuration bits and limits on the system
  clock, and that the ADC front end runs on its own adc_clk.
*/
// Function
// - Low hardware standby pin enters hardware standby; high means normal operation.
// - Thermal shutdown pulls low when channel 1 or 4 exceeds its limit.
// - Alert pulls low when any channel exceeds its own alert limit.
// - Five channels each have alert limits; only channels 1 and 4 have shutdown limits.
// - Default order is channel 1, 2, 3, local, 4, repeating.
// - Each finished conversion lands in its own channel's result register.
// - Fast mode bit selects channel-1 favouring order instead of the default.
// - Fast mode interleaves channel 1 with each other channel in turn.
// - Software stop bit set by the host puts the device in software standby.
// - Software standby disables the ADC; no conversions run.
// - Hardware standby stops the ADC clock; no conversions run.
// - Results and limits stay unchanged during either standby.
// - Hardware standby makes the serial slave interface inactive.
// - Software standby keeps the serial slave interface active.
// - Bus timeout monitor arms only after a start condition is seen.
// - Standby during a conversion aborts it without touching any result.
// - Serial interface resets when the bus stays low for 25 to 45 ms.
// - Channel 1 keeps 11 bits of result; others keep 8 bits.
`timescale 1ns/1ps
`default_nettype none

module tms_sequencer
#(
	parameter int TIMEOUT_COUNT = tms_pkg::TIMEOUT_CYCLES
) (
	// System clock and reset
	input wire logic clk,
	input wire logic rst,
	// ADC link clock
	input wire logic adc_clk,
	// Pins from outside
	input wire logic hw_standby_n,
	input wire logic smb_scl,
	input wire logic smb_sda,
	// Configuration from the register map
	input wire logic cfg_fast_ch1,
	input wire logic cfg_sw_stop,
	input wire tms_pkg::tms_limits_t limits,
	// ADC front end, adc_clk domain
	input wire logic adc_done,
	input wire logic [10:0] adc_result,
	output logic adc_start,
	output logic [2:0] adc_chan,
	// ADC power and clock control
	output logic adc_enable,
	output logic adc_clk_run,
	// Results
	output tms_pkg::tms_temps_t temps,
	// Open-drain alarm pins
	output logic alert_n_o,
	output logic alert_n_oe,
	output logic thermal_shutdown_n_o,
	output logic thermal_shutdown_n_oe,
	// Serial slave control
	output logic smb_active,
	output logic smb_timeout
);
	import tms_pkg::*;

	// -------------------------------------------------------------
	// Helper functions
	// -------------------------------------------------------------
	function automatic logic [2:0] seq_chan(input logic fast, input logic [2:0] pos);
		logic [2:0] ch;
		ch = CH_1;
		if (fast) begin
			if (pos[0]) begin
				unique case (pos[2:1])
					2'h0: ch = CH_2;
					2'h1: ch = CH_3;
					2'h2: ch = CH_LOCAL;
					2'h3: ch = CH_4;
				endcase
			end
		end else begin
			unique case (pos)
				3'h0: ch = CH_1;
				3'h1: ch = CH_2;
				3'h2: ch = CH_3;
				3'h3: ch = CH_LOCAL;
				default: ch = CH_4;
			endcase
		end
		return ch;
	endfunction

	// Signed compare of an 11-bit reading against an 8-bit limit scaled to 11 bits.
	function automatic logic exceeds(input logic [10:0] t, input logic [7:0] lim);
		return $signed(t) > $signed({lim, 3'h0});
	endfunction

	// -------------------------------------------------------------
	// Pin synchronisers
	// -------------------------------------------------------------
	logic [2:0] hw_standby_n_sync;
	logic [2:0] scl_sync;
	logic [2:0] sda_sync;
	logic hw_standby_n_n_s;
	logic scl_s;
	logic sda_s;
	logic scl_q;
	logic sda_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hw_standby_n_sync <= 3'h7;
			scl_sync <= 3'h7;
			sda_sync <= 3'h7;
		end else begin
			hw_standby_n_sync <= {hw_standby_n_sync[1:0], hw_standby_n};
			scl_sync <= {scl_sync[1:0], smb_scl};
			sda_sync <= {sda_sync[1:0], smb_sda};
		end
	end

	// A level counts only once the second and third stages agree.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hw_standby_n_n_s <= 1'b1;
			scl_s <= 1'b1;
			sda_s <= 1'b1;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			if (hw_standby_n_sync[1] == hw_standby_n_sync[2]) hw_standby_n_n_s <= hw_standby_n_sync[2];
			if (scl_sync[1] == scl_sync[2]) scl_s <= scl_sync[2];
			if (sda_sync[1] == sda_sync[2]) sda_s <= sda_sync[2];
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	// -------------------------------------------------------------
	// Standby decode
	// -------------------------------------------------------------
	wire hw_hw_standby_n = ~hw_standby_n_n_s;
	wire sw_hw_standby_n = cfg_sw_stop;
	wire standby = hw_hw_standby_n | sw_hw_standby_n;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			adc_enable <= 1'b0;
			adc_clk_run <= 1'b0;
			smb_active <= 1'b0;
		end else begin
			adc_enable <= ~standby;
			adc_clk_run <= ~hw_hw_standby_n;
			smb_active <= ~hw_hw_standby_n;
		end
	end

	// -------------------------------------------------------------
	// Bus timeout monitor
	// -------------------------------------------------------------
	logic to_armed;
	logic [TIMEOUT_W-1:0] to_count;
	wire bus_start = scl_s & scl_q & sda_q & ~sda_s;
	wire bus_stop = scl_s & scl_q & ~sda_q & sda_s;
	wire to_hit = to_armed & ~scl_s & (to_count == TIMEOUT_W'(TIMEOUT_COUNT - 1));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			to_armed <= 1'b0;
			to_count <= '0;
			smb_timeout <= 1'b0;
		end else begin
			smb_timeout <= to_hit;
			if (hw_hw_standby_n || bus_stop || to_hit) begin
				to_armed <= 1'b0;
			end else if (bus_start) begin
				to_armed <= 1'b1;
			end
			if (!to_armed || scl_s) begin
				to_count <= '0;
			end else begin
				to_count <= to_count + 1'b1;
			end
		end
	end

	// -------------------------------------------------------------
	// Result handshake from the ADC domain
	// -------------------------------------------------------------
	tms_conv_t res_word;
	logic res_tgl;
	logic [2:0] res_sync;
	logic req_tgl;
	logic [2:0] req_chan;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			res_sync <= 3'h0;
		end else begin
			res_sync <= {res_sync[1:0], res_tgl};
		end
	end
	wire res_evt = res_sync[1] ^ res_sync[2];

	// -------------------------------------------------------------
	// Conversion sequencer
	// -------------------------------------------------------------
	typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_DRAIN} tms_state_t;
	tms_state_t state;
	logic [2:0] seq_pos;
	logic fast_q;
	wire [2:0] seq_last = fast_q ? SEQ_LAST_FAST : SEQ_LAST_DEF;
	wire [2:0] next_pos = (cfg_fast_ch1 != fast_q || seq_pos == seq_last) ?
		SEQ_FIRST : seq_pos + 3'h1;
	wire store = (state == ST_BUSY) & ~standby & res_evt & res_word.ok;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			seq_pos <= SEQ_FIRST;
			fast_q <= 1'b0;
			req_tgl <= 1'b0;
			req_chan <= CH_1;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (standby) begin
						seq_pos <= SEQ_FIRST;
					end else begin
						fast_q <= cfg_fast_ch1;
						req_chan <= seq_chan(cfg_fast_ch1,
							(cfg_fast_ch1 != fast_q) ? SEQ_FIRST : seq_pos);
						if (cfg_fast_ch1 != fast_q) seq_pos <= SEQ_FIRST;
						req_tgl <= ~req_tgl;
						state <= ST_BUSY;
					end
				end
				ST_BUSY: begin
					if (standby) begin
						seq_pos <= SEQ_FIRST;
						state <= res_evt ? ST_IDLE : ST_DRAIN;
					end else if (res_evt) begin
						seq_pos <= next_pos;
						state <= ST_IDLE;
					end
				end
				ST_DRAIN: begin
					// The aborted result is consumed here and thrown away.
					seq_pos <= SEQ_FIRST;
					if (res_evt) state <= ST_IDLE;
				end
			endcase
		end
	end

	// -------------------------------------------------------------
	// Result registers
	// -------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			temps.ch1 <= TEMP_WIDE_RST;
			temps.ch2 <= TEMP_NARROW_RST;
			temps.ch3 <= TEMP_NARROW_RST;
			temps.local_ch <= TEMP_NARROW_RST;
			temps.ch4 <= TEMP_NARROW_RST;
		end else if (store) begin
			unique case (req_chan)
				CH_1: temps.ch1 <= res_word.data;
				CH_2: temps.ch2 <= res_word.data[WIDE_W-1:EXT_BITS];
				CH_3: temps.ch3 <= res_word.data[WIDE_W-1:EXT_BITS];
				CH_LOCAL: temps.local_ch <= res_word.data[WIDE_W-1:EXT_BITS];
				CH_4: temps.ch4 <= res_word.data[WIDE_W-1:EXT_BITS];
			endcase
		end
	end

	// -------------------------------------------------------------
	// Alarm outputs
	// -------------------------------------------------------------
	wire [4:0] alert_hits = {
		exceeds(temps.ch1, limits.alert_ch1),
		exceeds({temps.ch2, 3'h0}, limits.alert_ch2),
		exceeds({temps.ch3, 3'h0}, limits.alert_ch3),
		exceeds({temps.local_ch, 3'h0}, limits.alert_local),
		exceeds({temps.ch4, 3'h0}, limits.alert_ch4)
	};
	wire thermal_shutdown_n_hit = exceeds(temps.ch1, limits.thermal_shutdown_n_ch1) |
		exceeds({temps.ch4, 3'h0}, limits.thermal_shutdown_n_ch4);
	// Open drain: the pin is only ever pulled low, so the driven level is fixed.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			alert_n_o <= 1'b0;
			alert_n_oe <= 1'b0;
			thermal_shutdown_n_o <= 1'b0;
			thermal_shutdown_n_oe <= 1'b0;
		end else begin
			alert_n_o <= 1'b0;
			alert_n_oe <= |alert_hits;
			thermal_shutdown_n_o <= 1'b0;
			thermal_shutdown_n_oe <= thermal_shutdown_n_hit;
		end
	end

	// -------------------------------------------------------------
	// ADC link domain
	// -------------------------------------------------------------
	typedef enum logic {AS_IDLE, AS_CONV} tms_adc_state_t;
	tms_adc_state_t adc_state;
	logic [1:0] adc_rst_sync;
	logic [2:0] req_sync;
	logic [1:0] abort_sync;

	// Reset asserts at once but releases in step with adc_clk.
	always_ff @(posedge adc_clk or posedge rst) begin
		if (rst) begin
			adc_rst_sync <= 2'h3;
		end else begin
			adc_rst_sync <= {adc_rst_sync[0], 1'b0};
		end
	end
	wire adc_rst = adc_rst_sync[1];
	always_ff @(posedge adc_clk or posedge adc_rst) begin
		if (adc_rst) begin
			req_sync <= 3'h0;
			abort_sync <= 2'h3;
		end else begin
			req_sync <= {req_sync[1:0], req_tgl};
			abort_sync <= {abort_sync[0], ~adc_enable};
		end
	end
	wire req_evt = req_sync[1] ^ req_sync[2];
	wire adc_abort = abort_sync[1];

	// The request channel is held still by the handshake, so it is sampled as a word.
	always_ff @(posedge adc_clk or posedge adc_rst) begin
		if (adc_rst) begin
			adc_state <= AS_IDLE;
			adc_start <= 1'b0;
			adc_chan <= CH_1;
			res_word <= '0;
			res_tgl <= 1'b0;
		end else begin
			adc_start <= 1'b0;
			unique case (adc_state)
				AS_IDLE: begin
					if (req_evt) begin
						adc_chan <= req_chan;
						adc_start <= 1'b1;
						adc_state <= AS_CONV;
					end
				end
				AS_CONV: begin
					if (adc_done) begin
						res_word <= '{ok: 1'b1, data: adc_result};
						res_tgl <= ~res_tgl;
						adc_state <= AS_IDLE;
					end else if (adc_abort) begin
						res_word.ok <= 1'b0;
						res_tgl <= ~res_tgl;
						adc_state <= AS_IDLE;
					end
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// ### tb/tms_sequencer_assertions.sv
/* Checker on the sequencer's ports; bound to every instance.
   Assumes SCL and the config bits change away from the clk edge. */
`timescale 1ns/1ps
`default_nettype none
module tms_seq_chk
	import tms_pkg::*;
#(parameter int TIMEOUT_COUNT = 50) (
	// Clock, reset and inputs
	input wire logic clk,
	input wire logic rst,
	input wire logic hw_standby_n,
	input wire logic smb_scl,
	input wire logic cfg_sw_stop,
	// Outputs watched
	input wire logic adc_enable,
	input wire logic adc_clk_run,
	input wire logic smb_active,
	input wire logic smb_timeout,
	input wire logic alert_n_o,
	input wire logic thermal_shutdown_n_o,
	input wire tms_pkg::tms_temps_t temps
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Length of the present SCL low spell, to bound the timeout.
	int low_cnt = 0;
	always_ff @(posedge clk) low_cnt <= smb_scl ? 0 : low_cnt + 1;
	a_alert_pin_low: assert property (alert_n_o == 1'b0) else $error("alert drives high");
	a_shut_pin_low: assert property (thermal_shutdown_n_o == 1'b0) else $error("shutdown high");
	a_normal_adc_on: assert property ((hw_standby_n && !cfg_sw_stop) [*8] |-> adc_enable)
		else $error("adc off in normal mode");
	a_hw_clk_stop: assert property (!hw_standby_n [*8] |-> !adc_clk_run)
		else $error("adc clock runs in hw standby");
	a_hw_bus_off: assert property (!hw_standby_n [*8] |-> !smb_active)
		else $error("bus active in hw standby");
	a_sw_adc_off: assert property (cfg_sw_stop [*3] |-> !adc_enable)
		else $error("adc on in sw standby");
	a_sw_bus_on: assert property ((cfg_sw_stop && hw_standby_n) [*8] |-> smb_active)
		else $error("bus off in sw standby");
	a_hw_standby_n_keep_data: assert property (!adc_enable [*8] |=> $stable(temps))
		else $error("results change in standby");
	a_timeout_after_low: assert property (smb_timeout |->
		low_cnt >= TIMEOUT_COUNT && low_cnt <= TIMEOUT_COUNT + 8)
		else $error("timeout at wrong low time");
	a_timeout_one_pulse: assert property (smb_timeout |=> !smb_timeout)
		else $error("timeout pulse too long");
	cover property (smb_timeout);
	cover property (!adc_clk_run);
	cover property (cfg_sw_stop && smb_active);
endmodule
bind tms_sequencer tms_seq_chk #(.TIMEOUT_COUNT(TIMEOUT_COUNT)) chk_u (
	.clk(clk),
	.rst(rst),
	.hw_standby_n(hw_standby_n),
	.smb_scl(smb_scl),
	.cfg_sw_stop(cfg_sw_stop),
	.adc_enable(adc_enable),
	.adc_clk_run(adc_clk_run),
	.smb_active(smb_active),
	.smb_timeout(smb_timeout),
	.alert_n_o(alert_n_o),
	.thermal_shutdown_n_o(thermal_shutdown_n_o),
	.temps(temps)
);
`default_nettype wire

// ### tb/tms_adc_model.sv
/* ADC front end model: answers a start after a set delay.
   Assumes start and channel come from the sequencer on adc_clk. */
`timescale 1ns/1ps
`default_nettype none
module tms_adc_model (
	// Link clock and reset
	input wire logic adc_clk,
	input wire logic rst,
	// Requests and settings
	input wire logic adc_start,
	input wire logic [2:0] adc_chan,
	input wire logic [7:0] delay,
	input wire logic [4:0][10:0] val,
	// Answer
	output logic adc_done,
	output logic [10:0] adc_result
);
	logic busy;
	logic [7:0] cnt;
	logic [2:0] ch;
	// Outside a result the word toggles, so a stale value never looks valid.
	always_ff @(posedge adc_clk or posedge rst) begin
		if (rst) begin
			{busy, cnt, ch, adc_done, adc_result} <= '0;
		end else begin
			adc_done <= 1'b0;
			adc_result <= ~adc_result;
			if (adc_start) begin
				busy <= 1'b1;
				cnt <= delay;
				ch <= adc_chan;
			end else if (busy && cnt == 8'h00) begin
				busy <= 1'b0;
				adc_done <= 1'b1;
				adc_result <= val[ch];
			end else begin
				cnt <= cnt - 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ### tb/test_tms_sequencer.sv
/* Bench for the sequencer: ADC model on a 12 ns clock, bench as host.
   Assumes the checker is attached by its own bind. */
`timescale 1ns/1ps
`default_nettype none
module test_tms_sequencer;
	import tms_pkg::*;
	localparam int TO = 50;
	logic clk = 0, rst = 1, adc_clk = 0, hw_standby_n_n = 1, scl = 1, sda = 1, fast = 0, stop = 0;
	logic adc_done, adc_start, adc_enable, adc_clk_run, al_o, al_oe, sh_o, sh_oe, act, tmo;
	logic [10:0] adc_result;
	logic [2:0] adc_chan;
	logic [7:0] dly = 8'h04;
	logic [4:0][10:0] val = {11'h228, 11'h150, 11'h7f8, 11'h0cd, 11'h1b0};
	tms_limits_t lim = {7{8'h7f}};
	tms_temps_t temps;
	int fail_count = 0, check_count = 0, n_start = 0, n_to = 0;
	tms_sequencer #(.TIMEOUT_COUNT(TO)) dut_u (.clk(clk), .rst(rst), .adc_clk(adc_clk),
		.hw_standby_n(hw_standby_n_n), .smb_scl(scl), .smb_sda(sda), .cfg_fast_ch1(fast),
		.cfg_sw_stop(stop), .limits(lim), .adc_done(adc_done), .adc_result(adc_result),
		.adc_start(adc_start), .adc_chan(adc_chan), .adc_enable(adc_enable),
		.adc_clk_run(adc_clk_run), .temps(temps), .alert_n_o(al_o), .alert_n_oe(al_oe),
		.thermal_shutdown_n_o(sh_o), .thermal_shutdown_n_oe(sh_oe), .smb_active(act),
		.smb_timeout(tmo));
	tms_adc_model adc_u (.adc_clk(adc_clk), .rst(rst), .adc_start(adc_start),
		.adc_chan(adc_chan), .delay(dly), .val(val), .adc_done(adc_done),
		.adc_result(adc_result));
	initial forever #5 clk = ~clk;
	initial begin
		#3;
		forever #6 adc_clk = ~adc_clk;
	end
	// Counted at launch, so a start is already in the count when ws returns.
	always @(posedge adc_start) n_start++;
	always @(posedge clk) n_to += tmo;
	function automatic tms_temps_t exp_t(input logic [4:0][10:0] v);
		return {v[1], v[2][10:3], v[3][10:3], v[0][10:3], v[4][10:3]};
	endfunction
	task automatic stop_test();
		if (fail_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string n, input logic [42:0] e, input logic [42:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic ws(output logic [2:0] c);
		int k;
		k = 0;
		do begin
			@(posedge adc_clk);
			#1 k++;
		end while (adc_start !== 1'b1 && k < 400);
		c = adc_chan;
		if (k >= 400) begin
			chk("adc_start", 1, 0);
			stop_test();
		end
		@(negedge clk);
	endtask
	task automatic t_order(input logic f);
		logic [2:0] c;
		logic [7:0][2:0] fs = {3'h4, 3'h1, 3'h0, 3'h1, 3'h3, 3'h1, 3'h2, 3'h1};
		logic [4:0][2:0] ds = {3'h4, 3'h0, 3'h3, 3'h2, 3'h1};
		stop = 1;
		repeat (20) @(negedge clk);
		fast = f;
		stop = 0;
		for (int i = 0; i < 10; i++) begin
			ws(c);
			chk("adc_chan", f ? fs[i % 8] : ds[i % 5], c);
		end
		chk("temps", exp_t(val), temps);
	endtask
	task automatic t_alarm();
		tms_temps_t e;
		logic [4:0][7:0] t8;
		e = exp_t(val);
		t8 = {e.ch1[10:3], e.ch2, e.ch3, e.local_ch, e.ch4};
		chk("alarms idle", 0, {al_oe, sh_oe});
		for (int i = 0; i < 5; i++) begin
			lim[55 - 8 * i -: 8] = t8[4 - i];
			repeat (4) @(negedge clk);
			chk("alert at limit", i == 0, al_oe);
			lim[55 - 8 * i -: 8] = t8[4 - i] - 8'h01;
			repeat (4) @(negedge clk);
			chk("alert over", 1, al_oe);
			lim[55 - 8 * i -: 8] = 8'h7f;
		end
		lim.thermal_shutdown_n_ch1 = t8[4];
		repeat (4) @(negedge clk);
		chk("shut ch1", 1, {al_oe, sh_oe});
		lim.thermal_shutdown_n_ch1 = 8'h7f;
		lim.thermal_shutdown_n_ch4 = t8[0] - 8'h01;
		repeat (4) @(negedge clk);
		chk("shut ch4", 1, {al_oe, sh_oe});
		lim.thermal_shutdown_n_ch4 = 8'h7f;
		repeat (4) @(negedge clk);
		chk("shut off", 0, {al_oe, sh_oe});
	endtask
	task automatic t_timeout();
		int n;
		n = n_to;
		scl = 0;
		repeat (TO * 2) @(negedge clk);
		scl = 1;
		repeat (10) @(negedge clk);
		chk("unarmed", n, n_to);
		sda = 0;
		repeat (10) @(negedge clk);
		scl = 0;
		repeat (TO * 2 + 20) @(negedge clk);
		chk("timeouts", n + 1, n_to);
		scl = 1;
		sda = 1;
	endtask
	task automatic t_hw_standby_n();
		logic [2:0] c;
		tms_temps_t e;
		logic [4:0][10:0] v0;
		int n;
		e = exp_t(val);
		v0 = val;
		dly = 8'h60;
		ws(c);
		// Fresh values would show any write made by an aborted conversion.
		val = {5{11'h3aa}};
		stop = 1;
		n = n_start;
		repeat (300) @(negedge clk);
		chk("sw temps", e, temps);
		chk("sw starts", n, n_start);
		chk("sw bus", 1, act);
		stop = 0;
		ws(c);
		chk("sw resume", 1, c);
		hw_standby_n_n = 0;
		n = n_start;
		repeat (300) @(negedge clk);
		chk("hw temps", e, temps);
		chk("hw starts", n, n_start);
		chk("hw pins", 0, {act, adc_clk_run, adc_enable});
		val = v0;
		dly = 8'h04;
		hw_standby_n_n = 1;
		ws(c);
		chk("hw resume", 1, c);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst = 0;
		t_order(0);
		t_order(1);
		t_alarm();
		t_timeout();
		t_hw_standby_n();
		stop_test();
	end
endmodule
`default_nettype wire
